// ==== rtl/smsc_params.svh ====
`ifndef SMSC_PARAMS_SVH
`define SMSC_PARAMS_SVH

// Register offsets on the documented register port.
`define SMSC_OFF_DATA 8'h0C
`define SMSC_OFF_CTRL 8'h21
`define SMSC_OFF_STAT 8'h23
`define SMSC_OFF_ADDR_MID 8'h25
`define SMSC_OFF_ADDR_LOW 8'h27
`define SMSC_OFF_SEG_END 8'h2B
`define SMSC_OFF_SEG_UP 8'h2D
`define SMSC_OFF_SEG_LO 8'h2F

// Memory control register layout and reset value.
`define SMSC_CTRL_RESET 8'h38
`define SMSC_CTRL_BACKUP 7
`define SMSC_CTRL_MUX_HI 6
`define SMSC_CTRL_MUX_LO 3
`define SMSC_CTRL_CNT_EN 2
`define SMSC_CTRL_RD_EN 1
`define SMSC_CTRL_WR_EN 0

// Status register layout.
`define SMSC_STAT_WRAP 7
`define SMSC_STAT_SIZE 6
`define SMSC_SIZE_512K 1'b1

// Widths.
`define SMSC_ADDR_W 19
`define SMSC_SAMPLE_W 12
`define SMSC_ID_W 4
`define SMSC_PAIR_W 24
`define SMSC_WORD_W 16
`define SMSC_BYTE_W 8
`define SMSC_FIFO_DEPTH 8

// Segment layout: terminal field gives address bits 18..12.
`define SMSC_TERM_LOW 12'hFFF
`define SMSC_BASE_LOW 2'h0
`define SMSC_END_BASE_BIT 0

// Traffic register fields.
`define SMSC_SRC_MEM 2'h3
`define SMSC_MODE_CH1 2'h1
`define SMSC_MODE_CH2 2'h2
`define SMSC_MODE_ALT 2'h3

`endif

// ==== rtl/smsc_pkg.sv ====
`include "smsc_params.svh"

package smsc_pkg;

  typedef logic [`SMSC_ADDR_W-1:0] smsc_addr_t;
  typedef logic [`SMSC_PAIR_W-1:0] smsc_pair_t;
  typedef logic [`SMSC_WORD_W-1:0] smsc_word_t;
  typedef logic [`SMSC_BYTE_W-1:0] smsc_byte_t;
  typedef logic [`SMSC_SAMPLE_W-1:0] smsc_sample_t;
  typedef logic [`SMSC_ID_W-1:0] smsc_id_t;

endpackage : smsc_pkg

// ==== rtl/smsc_fifo.sv ====
`timescale 1ns/10ps

module smsc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] count;
  } smsc_fifo_state_s;

  smsc_fifo_state_s s_q;
  smsc_fifo_state_s s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wp + 1'b1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rp + 1'b1);
    end
    if (push && !pop) begin
      s_d.count = CW'(s_q.count + 1'b1);
    end else if (pop && !push) begin
      s_d.count = CW'(s_q.count - 1'b1);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : smsc_fifo

// ==== rtl/smsc_mem_ctrl.sv ====
`timescale 1ns/10ps
`include "smsc_params.svh"

// Summary of operation
// - Samples stored as 12-bit values, read back left-justified in 16 bits.
// - Low four bits of read word carry the channel identifier, else zero.
// - Data-presentation mode chooses which channel the data port returns.
// - Memory control register resets to 0x38.
// - Control bit 7 switches the memory battery backup.
// - Control bit 2 cleared halts the counter and arms a base reload.
// - Control bit 2 set runs the counter, reloading base after terminal.
// - Bit 1 selects read mode; memory drives fast bus only if sourced.
// - Bit 0 with bit 1 clear and bit 2 set writes converter samples at current address.
// - Read-only address registers report where the next sample goes.
// - Status bit 7 flags a wrap; bits 2..0 give address bits 18..16.
// - Status bit 6 reports memory size, always the 512K value.
// - Terminal field marks the segment's last location before base.
// - Terminal register bit 0 is base address bit 18.
// - Upper base register is bits 17..10, lower base is bits 9..2.
// - Base writes are staged; clearing then setting bit 2 loads them.
// - Mode 00 invalid, 01 channel 1, 10 channel 2, 11 alternating.
// - Four-bit identifier per channel appended on readout, never stored.
module smsc_mem_ctrl (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port.
  input wire smsc_pkg::smsc_byte_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire smsc_pkg::smsc_word_t reg_wdata,
  output smsc_pkg::smsc_word_t reg_rdata,
  output logic reg_rvalid,
  // Traffic and channel identifier fields from neighbouring registers.
  input wire logic [1:0] traffic_mode,
  input wire logic [1:0] traffic_src,
  input wire smsc_pkg::smsc_id_t chan1_id,
  input wire smsc_pkg::smsc_id_t chan2_id,
  // Converter sample stream, channel 2 in the upper half.
  input wire logic adc_valid,
  output logic adc_ready,
  input wire smsc_pkg::smsc_pair_t adc_data,
  // Sample memory.
  output smsc_pkg::smsc_addr_t sram_addr,
  input wire smsc_pkg::smsc_pair_t sram_dq_i,
  output smsc_pkg::smsc_pair_t sram_dq_o,
  output logic sram_dq_oe_n,
  output logic sram_we_n,
  output logic sram_oe_n,
  // Internal high-speed bus.
  output smsc_pkg::smsc_pair_t hs_data,
  output logic hs_valid,
  // Miscellaneous control outputs.
  output logic backup_en,
  output logic [3:0] timebase_mux
);
  import smsc_pkg::*;

  typedef struct packed {
    smsc_byte_t ctrl;
    smsc_byte_t seg_end;
    smsc_byte_t seg_up;
    smsc_byte_t seg_lo;
    smsc_addr_t cnt;
    logic arm;
    logic wrapped;
    logic alt_ch;
    logic half;
    smsc_pair_t rd_word;
    smsc_addr_t sram_addr;
    smsc_pair_t sram_dq_o;
    logic dq_oe_n;
    logic we_n;
    logic oe_n;
    smsc_pair_t hs_data;
    logic hs_valid;
    smsc_word_t rdata;
    logic rvalid;
  } smsc_state_s;

  smsc_state_s s_q;
  smsc_state_s s_d;

  logic fifo_valid;
  logic fifo_pop;
  smsc_pair_t fifo_data;
  logic wr_mode;
  logic rd_mode;
  logic cnt_run;
  smsc_addr_t term_addr;
  smsc_addr_t base_addr;

  assign wr_mode = s_q.ctrl[`SMSC_CTRL_WR_EN] & ~s_q.ctrl[`SMSC_CTRL_RD_EN];
  assign rd_mode = s_q.ctrl[`SMSC_CTRL_RD_EN];
  assign cnt_run = s_q.ctrl[`SMSC_CTRL_CNT_EN];
  assign term_addr = {s_q.seg_end[7:1], `SMSC_TERM_LOW};
  assign base_addr = {s_q.seg_end[`SMSC_END_BASE_BIT], s_q.seg_up,
                      s_q.seg_lo, `SMSC_BASE_LOW};

  // Samples drain only while writing with the counter running, so a halted
  // counter backs the stream up into the buffer and then to the converter.
  assign fifo_pop = fifo_valid & wr_mode & cnt_run;

  smsc_fifo #(
    .WIDTH(`SMSC_PAIR_W),
    .DEPTH(`SMSC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .in_data(adc_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_comb begin
    logic advance;
    logic sel_ch2;
    logic sel_ok;
    smsc_sample_t sample;
    smsc_id_t id;
    advance = 1'b0;
    sel_ch2 = 1'b0;
    sel_ok = 1'b1;
    sample = '0;
    id = '0;
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.we_n = 1'b1;
    s_d.dq_oe_n = 1'b1;
    s_d.sram_addr = s_q.cnt;
    s_d.oe_n = ~rd_mode;
    if (rd_mode) begin
      s_d.rd_word = sram_dq_i;
    end

    // Converter samples go to memory at the current address.
    if (fifo_pop) begin
      s_d.sram_dq_o = fifo_data;
      s_d.dq_oe_n = 1'b0;
      s_d.we_n = 1'b0;
      advance = 1'b1;
    end

    // Channel selection; alternation starts at the last fixed channel.
    case (traffic_mode)
      `SMSC_MODE_CH1: begin
        sel_ch2 = 1'b0;
        s_d.alt_ch = 1'b0;
        s_d.half = 1'b0;
      end
      `SMSC_MODE_CH2: begin
        sel_ch2 = 1'b1;
        s_d.alt_ch = 1'b1;
        s_d.half = 1'b0;
      end
      `SMSC_MODE_ALT: begin
        sel_ch2 = s_q.alt_ch;
      end
      default: begin
        sel_ok = 1'b0;
      end
    endcase
    sample = sel_ch2 ? s_q.rd_word[`SMSC_PAIR_W-1:`SMSC_SAMPLE_W]
                     : s_q.rd_word[`SMSC_SAMPLE_W-1:0];
    id = sel_ch2 ? chan2_id : chan1_id;

    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      case (reg_addr)
        `SMSC_OFF_DATA: begin
          s_d.rdata = sel_ok ? {sample, id} : '0;
          if (sel_ok && rd_mode) begin
            if (traffic_mode == `SMSC_MODE_ALT) begin
              s_d.alt_ch = ~s_q.alt_ch;
              s_d.half = ~s_q.half;
              advance = s_q.half;
            end else begin
              advance = 1'b1;
            end
          end
        end
        `SMSC_OFF_CTRL: s_d.rdata = {8'h00, s_q.ctrl};
        `SMSC_OFF_STAT: begin
          s_d.rdata = {8'h00, s_q.wrapped, `SMSC_SIZE_512K, 3'h0,
                       s_q.cnt[18:16]};
        end
        `SMSC_OFF_ADDR_MID: s_d.rdata = {8'h00, s_q.cnt[15:8]};
        `SMSC_OFF_ADDR_LOW: s_d.rdata = {8'h00, s_q.cnt[7:0]};
        `SMSC_OFF_SEG_END: s_d.rdata = {8'h00, s_q.seg_end};
        `SMSC_OFF_SEG_UP: s_d.rdata = {8'h00, s_q.seg_up};
        `SMSC_OFF_SEG_LO: s_d.rdata = {8'h00, s_q.seg_lo};
        default: s_d.rdata = '0;
      endcase
    end

    // The counter steps only while enabled and wraps at the terminal.
    if (advance && cnt_run) begin
      if (s_q.cnt == term_addr) begin
        s_d.cnt = base_addr;
        s_d.wrapped = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 19'h00001;
      end
    end

    if (reg_wr) begin
      case (reg_addr)
        `SMSC_OFF_CTRL: begin
          s_d.ctrl = reg_wdata[7:0];
          if (!reg_wdata[`SMSC_CTRL_CNT_EN]) begin
            s_d.arm = 1'b1;
          end else if (s_q.arm && !cnt_run) begin
            s_d.cnt = base_addr;
            s_d.arm = 1'b0;
            s_d.wrapped = 1'b0;
          end
        end
        `SMSC_OFF_SEG_END: s_d.seg_end = reg_wdata[7:0];
        `SMSC_OFF_SEG_UP: s_d.seg_up = reg_wdata[7:0];
        `SMSC_OFF_SEG_LO: s_d.seg_lo = reg_wdata[7:0];
        default: begin
        end
      endcase
    end

    s_d.hs_valid = rd_mode && (traffic_src == `SMSC_SRC_MEM);
    s_d.hs_data = s_d.hs_valid ? s_q.rd_word : '0;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ctrl <= `SMSC_CTRL_RESET;
      s_q.arm <= 1'b1;
      s_q.dq_oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign sram_addr = s_q.sram_addr;
  assign sram_dq_o = s_q.sram_dq_o;
  assign sram_dq_oe_n = s_q.dq_oe_n;
  assign sram_we_n = s_q.we_n;
  assign sram_oe_n = s_q.oe_n;
  assign hs_data = s_q.hs_data;
  assign hs_valid = s_q.hs_valid;
  assign backup_en = s_q.ctrl[`SMSC_CTRL_BACKUP];
  assign timebase_mux = s_q.ctrl[`SMSC_CTRL_MUX_HI:`SMSC_CTRL_MUX_LO];

endmodule : smsc_mem_ctrl

// ==== verification/smsc_ctrl_monitor.sv ====
`timescale 1ns/10ps

module smsc_ctrl_monitor (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port.
  input wire smsc_pkg::smsc_byte_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire smsc_pkg::smsc_word_t reg_wdata,
  input wire smsc_pkg::smsc_word_t reg_rdata,
  input wire logic reg_rvalid,
  // Traffic fields.
  input wire logic [1:0] traffic_mode,
  input wire smsc_pkg::smsc_id_t chan1_id,
  // Memory and fast bus.
  input wire logic sram_dq_oe_n,
  input wire logic sram_we_n,
  input wire logic sram_oe_n,
  input wire smsc_pkg::smsc_pair_t hs_data,
  input wire logic hs_valid,
  // Control outputs.
  input wire logic backup_en,
  input wire logic [3:0] timebase_mux
);
  import smsc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence data_rd;
    reg_rd && reg_addr == 8'h0C;
  endsequence
  sequence ch1_rd;
    data_rd ##0 traffic_mode == 2'h1;
  endsequence
  sequence ctrl_wr;
    reg_wr && reg_addr == 8'h21;
  endsequence
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  size_bit_a: assert property (reg_rd && reg_addr == 8'h23 |=>
    reg_rdata[6] && reg_rdata[5:3] == 3'h0) else $error("bad size bit");
  backup_bit_a: assert property (ctrl_wr |=>
    backup_en == $past(reg_wdata[7])) else $error("backup not set");
  mux_bits_a: assert property (ctrl_wr |=>
    timebase_mux == $past(reg_wdata[6:3])) else $error("mux not set");
  write_mode_a: assert property (!sram_we_n |->
    !sram_dq_oe_n && sram_oe_n) else $error("write while reading");
  hs_gate_a: assert property (hs_valid |-> !sram_oe_n)
    else $error("fast bus valid outside read mode");
  hs_idle_a: assert property (!hs_valid |-> hs_data == 24'h000000)
    else $error("fast bus data while idle");
  id_low_a: assert property (ch1_rd |=>
    reg_rdata[3:0] == $past(chan1_id)) else $error("bad id bits");
  mode_off_a: assert property (data_rd ##0 traffic_mode == 2'h0 |=>
    reg_rdata == 16'h0000) else $error("invalid mode gave data");
endmodule : smsc_ctrl_monitor

bind smsc_mem_ctrl smsc_ctrl_monitor u_mon (.clk_sys, .sys_rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .traffic_mode,
  .chan1_id, .sram_dq_oe_n, .sram_we_n, .sram_oe_n, .hs_data, .hs_valid,
  .backup_en, .timebase_mux);

// ==== verification/smsc_sram_model.sv ====
`timescale 1ns/10ps

module smsc_sram_model (
  // Clock.
  input wire logic clk_sys,
  // Memory pins.
  input wire smsc_pkg::smsc_addr_t sram_addr,
  input wire smsc_pkg::smsc_pair_t sram_dq_o,
  input wire logic sram_dq_oe_n,
  input wire logic sram_we_n,
  input wire logic sram_oe_n,
  output smsc_pkg::smsc_pair_t sram_dq_i
);
  import smsc_pkg::*;
  smsc_pair_t mem [smsc_addr_t];
  initial sram_dq_i = 24'h000000;
  // Released or unwritten lines toggle so stale data never looks valid.
  always @(posedge clk_sys) begin
    if (!sram_we_n && !sram_dq_oe_n) mem[sram_addr] = sram_dq_o;
    if (!sram_oe_n && mem.exists(sram_addr)) sram_dq_i <= mem[sram_addr];
    else sram_dq_i <= ~sram_dq_i;
  end
endmodule : smsc_sram_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps

module testbench;
  import smsc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  smsc_byte_t reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  smsc_word_t reg_wdata = 16'h0000;
  smsc_word_t reg_rdata, got;
  logic [1:0] traffic_mode = 2'h1;
  logic [1:0] traffic_src = 2'h0;
  smsc_id_t chan1_id = 4'h0;
  smsc_id_t chan2_id = 4'h0;
  logic adc_valid = 1'b0;
  smsc_pair_t adc_data = 24'h000000;
  smsc_addr_t sram_addr;
  smsc_pair_t sram_dq_i, sram_dq_o, hs_data;
  logic reg_rvalid, adc_ready, sram_dq_oe_n, sram_we_n, sram_oe_n, hs_valid;
  logic backup_en, ok;
  logic [3:0] timebase_mux;
  int err_total = 0;
  int check_count = 0;
  int n;
  int md[6] = '{1, 2, 0, 3, 3, 1};
  int ad[6] = '{0, 1, 0, 2, 2, 3};
  int c2[6] = '{0, 1, 0, 1, 0, 0};
  logic [31:0] seed = 32'h3303ED68;
  smsc_pair_t words [8];
  always #2 clk_sys = ~clk_sys;
  smsc_mem_ctrl u_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .traffic_mode, .traffic_src,
    .chan1_id, .chan2_id, .adc_valid, .adc_ready, .adc_data, .sram_addr,
    .sram_dq_i, .sram_dq_o, .sram_dq_oe_n, .sram_we_n, .sram_oe_n,
    .hs_data, .hs_valid, .backup_en, .timebase_mux);
  smsc_sram_model u_mem (.clk_sys, .sram_addr, .sram_dq_o, .sram_dq_oe_n,
    .sram_we_n, .sram_oe_n, .sram_dq_i);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic smsc_word_t expw(smsc_pair_t p, int ch2, smsc_id_t i);
    return {ch2 ? p[23:12] : p[11:0], i};
  endfunction : expw
  task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(smsc_byte_t a, smsc_byte_t d);
    reg_addr = a;
    reg_wdata = {8'h00, d};
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr
  // Reads are spaced so that memory data behind a counter step is fresh.
  task automatic rd(smsc_byte_t a, output smsc_word_t d);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
    cyc(4);
  endtask : rd
  task automatic send(smsc_pair_t w, output logic acc);
    logic r;
    acc = 1'b0;
    adc_data = w;
    adc_valid = 1'b1;
    for (int i = 0; i < 4 && !acc; i++) begin
      r = adc_ready;
      cyc(1);
      acc = r;
    end
  endtask : send
  initial begin
    #40000;
    err_total++;
    give_verdict();
  end
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    cyc(1);
    rd(8'h21, got);
    chk("ctrl", 16'h0038, got);
    chk("mux", 4'h7, timebase_mux);
    chk("backup", 1'b0, backup_en);
    rd(8'h23, got);
    chk("stat", 16'h0040, got);
    rd(8'h10, got);
    chk("unmapped", 16'h0000, got);
    $display("test reset done");
    wr(8'h2B, 8'h02);
    wr(8'h2D, 8'h07);
    wr(8'h2F, 8'hFF);
    rd(8'h2D, got);
    chk("seg_up", 16'h0007, got);
    wr(8'h21, 8'h00);
    wr(8'h21, 8'h05);
    for (int i = 0; i < 6; i++) begin
      words[i] = rnd();
      send(words[i], ok);
      chk("accept", 1'b1, ok);
    end
    adc_valid = 1'b0;
    cyc(12);
    for (int i = 0; i < 4; i++)
      chk("wrap_mem", words[i < 2 ? i + 4 : i],
        u_mem.mem[smsc_addr_t'(19'h1FFC + i)]);
    rd(8'h23, got);
    chk("wrapped", 16'h00C0, got);
    rd(8'h25, got);
    chk("mid", 16'h001F, got);
    rd(8'h27, got);
    chk("low", 16'h00FE, got);
    wr(8'h2F, 8'h00);
    rd(8'h27, got);
    chk("staged", 16'h00FE, got);
    $display("test segment done");
    wr(8'h21, 8'h01);
    n = 0;
    for (int i = 0; i < 9; i++) begin
      if (i < 8) words[i] = rnd();
      send(i < 8 ? words[i] : rnd(), ok);
      n += ok;
    end
    adc_valid = 1'b0;
    chk("fill", 8, n);
    chk("full", 1'b0, adc_ready);
    wr(8'h21, 8'h05);
    cyc(16);
    for (int i = 0; i < 8; i++)
      chk("drain", words[i], u_mem.mem[smsc_addr_t'(19'h1C00 + i)]);
    chk("empty", 1'b1, adc_ready);
    rd(8'h23, got);
    chk("unwrapped", 16'h0040, got);
    rd(8'h27, got);
    chk("low", 16'h0008, got);
    $display("test buffer done");
    chan1_id = smsc_id_t'(rnd());
    chan2_id = smsc_id_t'(rnd());
    traffic_src = 2'h3;
    wr(8'h21, 8'h00);
    wr(8'h21, 8'h86);
    chk("backup", 1'b1, backup_en);
    chk("hs_on", 1'b1, hs_valid);
    // Let the first word at the segment base reach the read latch.
    cyc(3);
    chk("hs_data", words[0], hs_data);
    for (int i = 0; i < 6; i++) begin
      traffic_mode = md[i];
      rd(8'h0C, got);
      chk("data", md[i] == 0 ? 16'h0000 : expw(words[ad[i]], c2[i],
        c2[i] ? chan2_id : chan1_id), got);
    end
    rd(8'h27, got);
    chk("low", 16'h0004, got);
    traffic_src = 2'h0;
    cyc(2);
    chk("hs_off", 1'b0, hs_valid);
    $display("test readback done");
    give_verdict();
  end
endmodule : testbench
